// File: core/event_notice_framer.sv
// The placing of the registers and the Avalon-MM slave port were left to the implementer.
`default_nettype none

// Overview of operation
// - Presence byte bit 0 marks insertion or removal; other bits are zero.
// - Insertion is reported only once the transceiver finished initialising.
// - Software request makes a data-transfer notice asking the controller to pull data.
// - Data-transfer notice has type 0x07, length then handle words.
// - Package-level notices use internal channel identifier 0x1F.
// - Partition notice, type 0x08, only when partitioning supported and enabled.
// - Any link change of an enabled partition raises a partition notice.
// - Partition word holds link state and change map; upper half zero.
// - Change map bit n flags a change of partition n+1.
// - Link state bit n is one while partition n+1 link is up.
// - Thermal shutdown notice, type 0x09, sent when the threshold trips.
// - PLDM notice has type 0x71 and carries pad bytes 24 to 45.
// - PLDM notice is gated by transport enable bit 1.
// - New PLDM request not yet answered by reply 0xD7 raises a notice.
// - PLDM notices stay quiet from query 0x56 until reply 0xD7.
// - SPDM notice has type 0x72 and carries pad bytes 24 to 45.
// - SPDM notice is gated by transport enable bit 2.
// - New SPDM request not yet answered by reply 0xE2 raises a notice.
// - SPDM notices stay quiet from query 0x61 until reply 0xE2.
// - Transceiver notice, type 0x06, sent when alerts trigger and notices enabled.
module event_notice_framer
   import notice_pkg::*;
#(
   parameter int         PARTITIONS   = 8,
   parameter bit         PART_SUPPORT = 1'b1,
   parameter logic [7:0] CAGE_NUMBER  = 8'h01
)
(
   // Clock, reset and enable.
   input  wire logic         CLK_SYS_IN,
   input  wire logic         RST_IN,
   input  wire logic         CE_IN,
   // Register bus, Avalon-MM slave.
   input  wire logic [4:0]   AVS_ADDRESS_IN,
   input  wire logic         AVS_READ_IN,
   input  wire logic         AVS_WRITE_IN,
   input  wire logic [31:0]  AVS_WRITEDATA_IN,
   input  wire logic [3:0]   AVS_BYTEENABLE_IN,
   output logic [31:0]       AVS_READDATA_OUT,
   output logic              AVS_WAITREQUEST_OUT,
   // Transceiver cage pins.
   input  wire logic         XCVR_PRESENT_IN,
   input  wire logic         XCVR_INIT_DONE_IN,
   input  wire logic         THERMAL_TRIP_IN,
   // Device-side event sources.
   input  wire logic [31:0]  XCVR_ALERTS_IN,
   input  wire logic [7:0]   PART_LINK_UP_IN,
   input  wire logic         PLDM_NEW_IN,
   input  wire logic         SPDM_NEW_IN,
   input  wire code_strobe_s CMD_SEEN_IN,
   input  wire code_strobe_s RSP_SENT_IN,
   // Notice word stream toward the packet transmitter.
   input  wire logic         NOTICE_READY_IN,
   output notice_word_s      NOTICE_OUT
);

   ////////////////////////////////////////////////////////////////////////////
   // Parameter checks.
   if (PARTITIONS < 1 || PARTITIONS > 8)
   begin : g_part_check
      $error("PARTITIONS must lie between 1 and 8.");
   end

   localparam logic [7:0] PART_VALID = 8'((16'h1 << PARTITIONS) - 16'h1);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      // Synchronisers and edge history.
      logic [1:0]        pres_sync;
      logic [1:0]        init_sync;
      logic [1:0]        therm_sync;
      logic              present;
      logic              therm;
      logic [31:0]       alert_prev;
      logic [7:0]        link_prev;
      // Pending events.
      logic              ins_wait;
      logic              pres_chg;
      logic              xcvr_pend;
      logic [7:0]        part_map;
      logic              therm_pend;
      logic              pldm_pend;
      logic              pldm_quiet;
      logic              spdm_pend;
      logic              spdm_quiet;
      logic              xfer_pend;
      // Registers.
      logic [2:0]        control;
      logic [7:0]        transport_en;
      logic [4:0]        channel_id;
      logic [7:0]        part_enable;
      logic [31:0]       xfer_length;
      logic [31:0]       xfer_handle;
      // Bus slave.
      logic              waitreq;
      logic [31:0]       rdata;
      // Framer.
      frame_state_e      fstate;
      logic [2:0][31:0]  words;
      logic [1:0]        widx;
      logic [1:0]        wlast;
      logic [4:0]        fchan;
      logic [5:0]        fpad;
      notice_word_s      out;
   } state_s;

   state_s st;
   state_s next_st;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic code_hit(input code_strobe_s s, input logic [7:0] code);
      code_hit = s.valid && (s.code == code);
   endfunction

   function automatic logic [31:0] type_word(input logic [7:0] code, input logic [7:0] mid,
                                             input logic [7:0] pres);
      type_word = {8'h00, pres, mid, code};
   endfunction

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      merge_bytes = r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic        ins_rise;
   logic        pres_fall;
   logic        alert_new;
   logic [7:0]  link_chg;
   logic        part_on;
   logic        pldm_go;
   logic        spdm_go;
   logic        bus_take;
   logic        wr_take;
   logic [31:0] status;
   logic [31:0] rd_mux;
   logic        sent;

   always_comb
   begin
      next_st   = st;
      ins_rise  = st.pres_sync[1] && !st.present;
      pres_fall = !st.pres_sync[1] && st.present;
      alert_new = |(XCVR_ALERTS_IN & ~st.alert_prev);
      link_chg  = (PART_LINK_UP_IN ^ st.link_prev) & st.part_enable & PART_VALID;
      part_on   = PART_SUPPORT && st.control[CTL_PART_EN];
      pldm_go   = st.pldm_pend && !st.pldm_quiet && st.transport_en[TSE_PLDM];
      spdm_go   = st.spdm_pend && !st.spdm_quiet && st.transport_en[TSE_SPDM];
      bus_take  = (AVS_READ_IN || AVS_WRITE_IN) && st.waitreq;
      wr_take   = AVS_WRITE_IN && !st.waitreq;
      sent      = 1'b0;

      status = 32'h0;
      status[STS_XCVR]    = st.xcvr_pend;
      status[STS_PART]    = |st.part_map;
      status[STS_THERMAL] = st.therm_pend;
      status[STS_PLDM]    = st.pldm_pend;
      status[STS_SPDM]    = st.spdm_pend;
      status[STS_XFER]    = st.xfer_pend;
      status[STS_PLDM_QT] = st.pldm_quiet;
      status[STS_SPDM_QT] = st.spdm_quiet;
      status[STS_PRESENT] = st.present;
      status[STS_BUSY]    = (st.fstate != FR_IDLE);

      case (AVS_ADDRESS_IN)
         OFS_CONTROL:      rd_mux = {30'h0, st.control[1:0]};
         OFS_TRANSPORT_EN: rd_mux = {24'h0, st.transport_en};
         OFS_CHANNEL_ID:   rd_mux = {27'h0, st.channel_id};
         OFS_PART_ENABLE:  rd_mux = {24'h0, st.part_enable};
         OFS_XFER_LENGTH:  rd_mux = st.xfer_length;
         OFS_XFER_HANDLE:  rd_mux = st.xfer_handle;
         OFS_STATUS:       rd_mux = status;
         default:          rd_mux = 32'h0;
      endcase

      if (CE_IN)
      begin
         /////////////////////////////////////////////////////////////////////
         // Pin synchronisers and edge history.
         next_st.pres_sync  = {st.pres_sync[0], XCVR_PRESENT_IN};
         next_st.init_sync  = {st.init_sync[0], XCVR_INIT_DONE_IN};
         next_st.therm_sync = {st.therm_sync[0], THERMAL_TRIP_IN};
         next_st.present    = st.pres_sync[1];
         next_st.therm      = st.therm_sync[1];
         next_st.alert_prev = XCVR_ALERTS_IN;
         next_st.link_prev  = PART_LINK_UP_IN;

         /////////////////////////////////////////////////////////////////////
         // Bus slave: answer one cycle after the request is seen.
         next_st.waitreq = !bus_take;
         if (bus_take)
            next_st.rdata = AVS_READ_IN ? rd_mux : 32'h0;
         if (wr_take)
         begin
            case (AVS_ADDRESS_IN)
               OFS_CONTROL:
                  if (AVS_BYTEENABLE_IN[0])
                     next_st.control[1:0] = AVS_WRITEDATA_IN[1:0];
               OFS_TRANSPORT_EN:
                  if (AVS_BYTEENABLE_IN[0])
                     next_st.transport_en = AVS_WRITEDATA_IN[7:0];
               OFS_CHANNEL_ID:
                  if (AVS_BYTEENABLE_IN[0])
                     next_st.channel_id = AVS_WRITEDATA_IN[4:0];
               OFS_PART_ENABLE:
                  if (AVS_BYTEENABLE_IN[0])
                     next_st.part_enable = AVS_WRITEDATA_IN[7:0];
               OFS_XFER_LENGTH:
                  next_st.xfer_length = merge_bytes(st.xfer_length, AVS_WRITEDATA_IN,
                                                    AVS_BYTEENABLE_IN);
               OFS_XFER_HANDLE:
                  next_st.xfer_handle = merge_bytes(st.xfer_handle, AVS_WRITEDATA_IN,
                                                    AVS_BYTEENABLE_IN);
               default:
                  next_st.control = st.control;
            endcase
         end

         /////////////////////////////////////////////////////////////////////
         // Framer: pick one pending notice and retire it, then stream its words.
         case (st.fstate)
            FR_IDLE:
            begin
               next_st.widx = 2'd0;
               next_st.fpad = PAD_NONE;
               if (st.therm_pend)
               begin
                  next_st.words[0] = type_word(TYPE_THERMAL, 8'h00, 8'h00);
                  next_st.wlast    = 2'd0;
                  next_st.fchan    = CHAN_PACKAGE;
                  next_st.fstate   = FR_SEND;
                  next_st.therm_pend = 1'b0;
               end
               else if (st.xcvr_pend && st.control[CTL_NOTICE_EN])
               begin
                  next_st.words[0] = type_word(TYPE_XCVR, CAGE_NUMBER,
                                        8'(st.pres_chg) << PRESENCE_CHANGE_BIT);
                  next_st.words[1] = XCVR_ALERTS_IN;
                  next_st.words[2] = 32'h0;
                  next_st.wlast    = 2'd2;
                  next_st.fchan    = st.channel_id;
                  next_st.fstate   = FR_SEND;
                  next_st.xcvr_pend = 1'b0;
                  next_st.pres_chg  = 1'b0;
               end
               else if ((|st.part_map) && part_on)
               begin
                  next_st.words[0] = type_word(TYPE_PART, 8'h00, 8'h00);
                  next_st.words[1] = {16'h0, st.part_map,
                                      PART_LINK_UP_IN & PART_VALID};
                  next_st.wlast    = 2'd1;
                  next_st.fchan    = st.channel_id;
                  next_st.fstate   = FR_SEND;
                  next_st.part_map = 8'h00;
               end
               else if (pldm_go)
               begin
                  next_st.words[0] = type_word(TYPE_PLDM, 8'h00, 8'h00);
                  next_st.wlast    = 2'd0;
                  next_st.fchan    = CHAN_PACKAGE;
                  next_st.fpad     = PAD_PENDING;
                  next_st.fstate   = FR_SEND;
                  next_st.pldm_pend = 1'b0;
               end
               else if (spdm_go)
               begin
                  next_st.words[0] = type_word(TYPE_SPDM, 8'h00, 8'h00);
                  next_st.wlast    = 2'd0;
                  next_st.fchan    = CHAN_PACKAGE;
                  next_st.fpad     = PAD_PENDING;
                  next_st.fstate   = FR_SEND;
                  next_st.spdm_pend = 1'b0;
               end
               else if (st.xfer_pend)
               begin
                  next_st.words[0] = type_word(TYPE_XFER, 8'h00, 8'h00);
                  next_st.words[1] = st.xfer_length;
                  next_st.words[2] = st.xfer_handle;
                  next_st.wlast    = 2'd2;
                  next_st.fchan    = CHAN_PACKAGE;
                  next_st.fstate   = FR_SEND;
                  next_st.xfer_pend = 1'b0;
               end
            end
            FR_SEND:
            begin
               if (!st.out.valid || NOTICE_READY_IN)
               begin
                  if (st.out.valid && st.out.last)
                  begin
                     sent = 1'b1;
                  end
                  else
                  begin
                     next_st.out.valid     = 1'b1;
                     next_st.out.data      = st.words[st.widx];
                     next_st.out.last      = (st.widx == st.wlast);
                     next_st.out.channel   = st.fchan;
                     next_st.out.pad_bytes = st.fpad;
                     next_st.widx          = st.widx + 2'd1;
                  end
               end
               if (sent)
               begin
                  next_st.out    = '0;
                  next_st.fstate = FR_IDLE;
               end
            end
            default:
               next_st.fstate = FR_IDLE;
         endcase

         /////////////////////////////////////////////////////////////////////
         // Event capture; every set is applied after the retire so it wins.
         if (pres_fall)
         begin
            next_st.pres_chg  = 1'b1;
            next_st.xcvr_pend = 1'b1;
            next_st.ins_wait  = 1'b0;
         end
         else if (ins_rise)
            next_st.ins_wait = 1'b1;
         else if (st.ins_wait && st.present && st.init_sync[1])
         begin
            next_st.ins_wait  = 1'b0;
            next_st.pres_chg  = 1'b1;
            next_st.xcvr_pend = 1'b1;
         end
         if (alert_new)
            next_st.xcvr_pend = 1'b1;
         next_st.part_map = part_on ? (next_st.part_map | link_chg) : 8'h00;
         if (st.therm_sync[1] && !st.therm)
            next_st.therm_pend = 1'b1;
         if (wr_take && AVS_ADDRESS_IN == OFS_CONTROL && AVS_BYTEENABLE_IN[0]
             && AVS_WRITEDATA_IN[CTL_XFER_REQ])
            next_st.xfer_pend = 1'b1;

         if (code_hit(CMD_SEEN_IN, CMD_PLDM_QUERY))
            next_st.pldm_quiet = 1'b1;
         if (code_hit(RSP_SENT_IN, RSP_PLDM_REPLY))
         begin
            next_st.pldm_quiet = 1'b0;
            next_st.pldm_pend  = 1'b0;
         end
         if (PLDM_NEW_IN)
            next_st.pldm_pend = 1'b1;
         if (code_hit(CMD_SEEN_IN, CMD_SPDM_QUERY))
            next_st.spdm_quiet = 1'b1;
         if (code_hit(RSP_SENT_IN, RSP_SPDM_REPLY))
         begin
            next_st.spdm_quiet = 1'b0;
            next_st.spdm_pend  = 1'b0;
         end
         if (SPDM_NEW_IN)
            next_st.spdm_pend = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK_SYS_IN)
   begin
      if (RST_IN)
      begin
         st              <= '0;
         st.control      <= RST_CONTROL;
         st.transport_en <= RST_TRANSPORT_EN;
         st.channel_id   <= RST_CHANNEL_ID;
         st.part_enable  <= RST_PART_ENABLE;
         st.waitreq      <= 1'b1;
         st.fstate       <= FR_IDLE;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign AVS_READDATA_OUT    = st.rdata;
   assign AVS_WAITREQUEST_OUT = st.waitreq;
   assign NOTICE_OUT          = st.out;

endmodule
`default_nettype wire

// File: inc/notice_pkg.sv
`default_nettype none
package notice_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on the 32-bit bus.
   localparam logic [4:0] OFS_CONTROL      = 5'h00;
   localparam logic [4:0] OFS_TRANSPORT_EN = 5'h04;
   localparam logic [4:0] OFS_CHANNEL_ID   = 5'h08;
   localparam logic [4:0] OFS_PART_ENABLE  = 5'h0c;
   localparam logic [4:0] OFS_XFER_LENGTH  = 5'h10;
   localparam logic [4:0] OFS_XFER_HANDLE  = 5'h14;
   localparam logic [4:0] OFS_STATUS       = 5'h18;

   // Control register fields.
   localparam int CTL_NOTICE_EN = 0;
   localparam int CTL_PART_EN   = 1;
   localparam int CTL_XFER_REQ  = 2;

   // Transport-specific notice enable field bits.
   localparam int TSE_PLDM = 1;
   localparam int TSE_SPDM = 2;

   // Status register fields.
   localparam int STS_XCVR     = 0;
   localparam int STS_PART     = 1;
   localparam int STS_THERMAL  = 2;
   localparam int STS_PLDM     = 3;
   localparam int STS_SPDM     = 4;
   localparam int STS_XFER     = 5;
   localparam int STS_PLDM_QT  = 6;
   localparam int STS_SPDM_QT  = 7;
   localparam int STS_PRESENT  = 8;
   localparam int STS_BUSY     = 9;

   // Reset values.
   localparam logic [2:0] RST_CONTROL      = 3'h0;
   localparam logic [7:0] RST_TRANSPORT_EN = 8'h00;
   localparam logic [4:0] RST_CHANNEL_ID   = 5'h00;
   localparam logic [7:0] RST_PART_ENABLE  = 8'hff;

   ////////////////////////////////////////////////////////////////////////////
   // Notice type codes and channel identifiers.
   localparam logic [7:0] TYPE_XCVR     = 8'h06;
   localparam logic [7:0] TYPE_XFER     = 8'h07;
   localparam logic [7:0] TYPE_PART     = 8'h08;
   localparam logic [7:0] TYPE_THERMAL  = 8'h09;
   localparam logic [7:0] TYPE_PLDM     = 8'h71;
   localparam logic [7:0] TYPE_SPDM     = 8'h72;
   localparam logic [4:0] CHAN_PACKAGE  = 5'h1f;

   // Command and response codes that steer the pending-request notices.
   localparam logic [7:0] CMD_PLDM_QUERY = 8'h56;
   localparam logic [7:0] RSP_PLDM_REPLY = 8'hd7;
   localparam logic [7:0] CMD_SPDM_QUERY = 8'h61;
   localparam logic [7:0] RSP_SPDM_REPLY = 8'he2;

   // Pad bytes after the checksum word (bytes 24 to 45).
   localparam logic [5:0] PAD_PENDING = 6'h16;
   localparam logic [5:0] PAD_NONE    = 6'h00;

   // Presence bit within the presence byte.
   localparam int PRESENCE_CHANGE_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      FR_IDLE = 2'b00,
      FR_SEND = 2'b01
   } frame_state_e;

   // One word of a notice, starting at byte 16; the checksum follows it.
   typedef struct packed {
      logic        valid;
      logic [31:0] data;
      logic        last;
      logic [4:0]  channel;
      logic [5:0]  pad_bytes;
   } notice_word_s;

   typedef struct packed {
      logic [7:0] code;
      logic       valid;
   } code_strobe_s;

endpackage
`default_nettype wire

// File: testbench/notice_properties.sv
`default_nettype none
module notice_properties
   import notice_pkg::*;
(
   // Watched ports.
   input wire logic         CLK_SYS_IN,
   input wire logic         RST_IN,
   input wire logic         CE_IN,
   input wire logic         AVS_READ_IN,
   input wire logic         AVS_WRITE_IN,
   input wire logic         AVS_WAITREQUEST_OUT,
   input wire logic         NOTICE_READY_IN,
   input wire notice_word_s NOTICE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic head;
   logic hd;
   logic [7:0] ty;
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   // Marks the word that opens a notice.
   always_ff @(posedge CLK_SYS_IN)
      if (RST_IN)
         head <= 1'b1;
      else if (NOTICE_OUT.valid && NOTICE_READY_IN)
         head <= NOTICE_OUT.last;
   assign hd = NOTICE_OUT.valid && head;
   assign ty = NOTICE_OUT.data[7:0];
   chk_thermal_word: assert property (hd && ty == 8'h09 |->
      NOTICE_OUT[43:0] == {32'h9, 1'b1, 5'h1f, 6'h0}) else $error("thermal word bad");
   chk_pldm_word: assert property (hd && ty == 8'h71 |->
      NOTICE_OUT[43:0] == {32'h71, 1'b1, 5'h1f, 6'h16}) else $error("pldm word bad");
   chk_spdm_word: assert property (hd && ty == 8'h72 |->
      NOTICE_OUT[43:0] == {32'h72, 1'b1, 5'h1f, 6'h16}) else $error("spdm word bad");
   chk_xfer_head: assert property (hd && ty == 8'h07 |->
      NOTICE_OUT.data == 32'h7 && !NOTICE_OUT.last && NOTICE_OUT.channel == 5'h1f)
      else $error("transfer head bad");
   chk_xcvr_rsvd: assert property (hd && ty == 8'h06 |->
      NOTICE_OUT.data[31:17] == 15'h0 && !NOTICE_OUT.last) else $error("presence bad");
   chk_part_head: assert property (hd && ty == 8'h08 |->
      NOTICE_OUT.data == 32'h8 && !NOTICE_OUT.last) else $error("partition head bad");
   chk_type_known: assert property (hd |->
      ty inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h71, 8'h72}) else $error("unknown type");
   chk_word_hold: assert property (NOTICE_OUT.valid && !NOTICE_READY_IN |=>
      NOTICE_OUT.valid && $stable(NOTICE_OUT.data)) else $error("word not held");
   chk_frame_gap: assert property (NOTICE_OUT.valid && NOTICE_OUT.last && NOTICE_READY_IN
      |=> !NOTICE_OUT.valid) else $error("no gap after last");
   chk_bus_answer: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
      && CE_IN |=> !AVS_WAITREQUEST_OUT) else $error("bus answer late");
   chk_bus_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
      else $error("waitrequest low too long");
endmodule
`default_nettype wire

// File: testbench/notice_sink.sv
`default_nettype none
module notice_sink
(
   // Clock and reset.
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Stream handshake.
   output logic      ready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // The controller stalls at random, so words must be held across waits.
   always_ff @(posedge clk_in)
      if (rst_in)
         ready_out <= 1'b0;
      else
         ready_out <= ($urandom % 4) != 0;
endmodule
`default_nettype wire

// File: testbench/tb.sv
`default_nettype none
module tb;
   import notice_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ce = 1'b1, wait_req, ready;
   logic present = 1'b0, init_done = 1'b0, trip = 1'b0, pldm_new = 1'b0, spdm_new = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, alerts = 32'h0, r, len, hdl;
   logic [7:0] link = 8'h00, k;
   code_strobe_s cmd = '0, rsp = '0;
   notice_word_s nout, got[$];
   int mismatches = 0, cmp_count = 0;
   always #2 clk = ~clk;
   event_notice_framer u_event_notice_framer (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce),
      .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
      .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wait_req),
      .XCVR_PRESENT_IN(present), .XCVR_INIT_DONE_IN(init_done), .THERMAL_TRIP_IN(trip),
      .XCVR_ALERTS_IN(alerts), .PART_LINK_UP_IN(link), .PLDM_NEW_IN(pldm_new),
      .SPDM_NEW_IN(spdm_new), .CMD_SEEN_IN(cmd), .RSP_SENT_IN(rsp),
      .NOTICE_READY_IN(ready), .NOTICE_OUT(nout));
   notice_sink u_notice_sink (.clk_in(clk), .rst_in(rst), .ready_out(ready));
   always @(posedge clk)
      if (!rst && nout.valid && ready)
         got.push_back(nout);
   ////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [44:0] g, input logic [44:0] e);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
      int i;
      i = 0;
      @(posedge clk);
      addr <= a;
      rd <= !w;
      wr <= w;
      wdata <= d;
      do
         @(posedge clk);
      while (wait_req && ++i < 50);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (wait_req)
      begin
         mismatches++;
         conclude();
      end
   endtask
   task automatic expect_word(input logic [31:0] d, input logic l, input logic [4:0] c,
                              input logic [5:0] p);
      int i;
      for (i = 0; i < 300 && got.size() == 0; i++)
         @(posedge clk);
      if (got.size() == 0)
      begin
         mismatches++;
         conclude();
      end
      check(got.pop_front(), {1'b1, d, l, c, p});
   endtask
   task automatic expect_none();
      repeat (60) @(posedge clk);
      check(45'(got.size()), 45'h0);
   endtask
   task automatic fire(input int s, input logic [7:0] c);
      @(posedge clk);
      pldm_new <= s == 0;
      spdm_new <= s == 1;
      cmd <= {c, s == 2};
      rsp <= {c, s == 3};
      @(posedge clk);
      {pldm_new, spdm_new, cmd, rsp} <= '0;
   endtask
   task automatic pend(input int s);
      logic [31:0] t;
      t = s ? 32'h72 : 32'h71;
      bus(OFS_TRANSPORT_EN, 1'b1, 32'h0);
      fire(s, 8'h00);
      expect_none();
      bus(OFS_TRANSPORT_EN, 1'b1, s ? 32'h4 : 32'h2);
      expect_word(t, 1'b1, 5'h1f, 6'h16);
      fire(2, s ? 8'h61 : 8'h56);
      fire(s, 8'h00);
      expect_none();
      fire(3, s ? 8'he2 : 8'hd7);
      expect_none();
      fire(s, 8'h00);
      expect_word(t, 1'b1, 5'h1f, 6'h16);
      $display("Test pending %0d done", s);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      conclude();
   end
   initial
   begin
      void'($urandom(32'h58cd92da));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(OFS_PART_ENABLE, 1'b0, 32'h0);
      check(45'(r), 45'hff);
      bus(5'h1c, 1'b0, 32'h0);
      check(45'(r), 45'h0);
      trip <= 1'b1;
      expect_word(32'h9, 1'b1, 5'h1f, 6'h0);
      $display("Test thermal done");
      pend(0);
      pend(1);
      len = $urandom;
      hdl = $urandom;
      bus(OFS_XFER_LENGTH, 1'b1, len);
      bus(OFS_XFER_HANDLE, 1'b1, hdl);
      bus(OFS_CONTROL, 1'b1, 32'h4);
      expect_word(32'h7, 1'b0, 5'h1f, 6'h0);
      expect_word(len, 1'b0, 5'h1f, 6'h0);
      expect_word(hdl, 1'b1, 5'h1f, 6'h0);
      $display("Test transfer done");
      k = 8'($urandom) | 8'h81;
      link <= 8'h0f;
      bus(OFS_CHANNEL_ID, 1'b1, 32'h3);
      bus(OFS_CONTROL, 1'b1, 32'h2);
      link <= k;
      expect_word(32'h8, 1'b0, 5'h03, 6'h0);
      expect_word({16'h0, k ^ 8'h0f, k}, 1'b1, 5'h03, 6'h0);
      bus(OFS_CONTROL, 1'b1, 32'h1);
      link <= ~k;
      expect_none();
      $display("Test partition done");
      present <= 1'b1;
      expect_none();
      init_done <= 1'b1;
      expect_word(32'h00010106, 1'b0, 5'h03, 6'h0);
      expect_word(32'h0, 1'b0, 5'h03, 6'h0);
      expect_word(32'h0, 1'b1, 5'h03, 6'h0);
      alerts <= $urandom | 32'h1;
      expect_word(32'h00000106, 1'b0, 5'h03, 6'h0);
      expect_word(alerts, 1'b0, 5'h03, 6'h0);
      expect_word(32'h0, 1'b1, 5'h03, 6'h0);
      ce <= 1'b0;
      present <= 1'b0;
      expect_none();
      ce <= 1'b1;
      expect_word(32'h00010106, 1'b0, 5'h03, 6'h0);
      expect_word(alerts, 1'b0, 5'h03, 6'h0);
      expect_word(32'h0, 1'b1, 5'h03, 6'h0);
      $display("Test transceiver done");
      conclude();
   end
endmodule
bind event_notice_framer notice_properties u_notice_properties (
   .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .CE_IN(CE_IN), .AVS_READ_IN(AVS_READ_IN),
   .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .NOTICE_READY_IN(NOTICE_READY_IN), .NOTICE_OUT(NOTICE_OUT));
`default_nettype wire
